/* File: logic/rpc_pkg.sv */
// Purpose: Shared constants and carriers for the register preload and power-up clear block
// Assumes: 100 MHz ref_clk; the device clock, output-enable and output pins are asynchronous and synchronised inside
// Notes: Times are in ns; cycle counts derive from them
package rpc_pkg;
    // Number of registered outputs
    localparam int NUM_REGS = 8;
    // System clock period in ns
    localparam int CLK_PERIOD_NS = 10;
    // Least preload settling time in ns
    localparam int PRELOAD_SETTLE_NS = 100;
    // Settling time in cycles, rounded up, at least one
    localparam int PRELOAD_SETTLE_CYC = (PRELOAD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Register value after power-up clear
    localparam logic [NUM_REGS-1:0] REG_CLEAR_VAL = 8'h00;
    // Width of the settling counter
    localparam int SETTLE_W = 8;

    // Sampled pin levels seen from the outside
    typedef struct packed {
        logic dev_clk;
        logic out_en_n;
        logic preload_high_voltage_level;
    } rpc_ctrl_pins_t;

    // Preload sequencer states
    typedef enum logic [1:0] {
        RPC_NORMAL = 2'b00,
        RPC_ARMED = 2'b01,
        RPC_LOADED = 2'b10
    } rpc_state_t;
endpackage

/* File: logic/rpc_sync.sv */
// Purpose: Two flip-flop synchroniser for a bus of pin levels
// Assumes: Inputs are asynchronous to ref_clk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module rpc_sync #(
    parameter int WIDTH = 1
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // First and second stage
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // Next values of both stages
    always_comb begin
        meta_next = meta_reg;
        sync_next = sync_reg;
        if (clk_en) begin
            meta_next = async_in;
            sync_next = meta_reg;
        end
    end

    // Stage registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule

/* File: logic/rpc_preload.sv */
// Purpose: Output registers with test preload and power-up clear
// Assumes: Pins sampled on ref_clk; sys_rst stands for power-up
// Notes: Pins pass two flip-flops; each group of state has its own pair of processes
// Operation
// - Clock pulse captures forced pin level
// - Device drives preloaded value after exit
// - Each register loads alone, others kept
// - Power-up clears all registered outputs
`timescale 1ns/1ps
module rpc_preload #(
    parameter int NUM_REGS = rpc_pkg::NUM_REGS,
    parameter int SETTLE_CYC = rpc_pkg::PRELOAD_SETTLE_CYC
) (
    // System clock, reset, enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Device pins from outside
    input wire rpc_pkg::rpc_ctrl_pins_t ctrl_pins,
    input wire logic [NUM_REGS-1:0] load_sel,
    input wire logic [NUM_REGS-1:0] next_state,
    // Registered output pins, split into three signals
    input wire logic [NUM_REGS-1:0] q_pin_in,
    output logic [NUM_REGS-1:0] q_pin_out,
    output logic [NUM_REGS-1:0] q_pin_oe,
    // Status
    output logic preload_active,
    output logic settle_done
);
    // Synchronised pins
    logic [NUM_REGS+2:0] raw_bus;
    logic [NUM_REGS+2:0] sync_bus;
    logic dclk_s;
    logic oe_n_s;
    logic hv_s;
    logic [NUM_REGS-1:0] qin_s;
    // Clock edge detect
    logic dclk_prev_reg;
    logic dclk_prev_next;
    logic dclk_rise;
    // Output registers
    logic [NUM_REGS-1:0] q_reg;
    logic [NUM_REGS-1:0] q_next;
    // Sequencer
    rpc_pkg::rpc_state_t state_reg;
    rpc_pkg::rpc_state_t state_next;
    logic [rpc_pkg::SETTLE_W-1:0] settle_reg;
    logic [rpc_pkg::SETTLE_W-1:0] settle_next;
    // Decoded sequencer events
    logic in_normal; // Sequencer idle, pins may be driven
    logic enter_req; // Preload level seen with clock pin low
    logic capture_req; // Clock pulse while armed
    logic exit_req; // Preload level gone after capture

    // Width of the settling counter, for sized casts
    localparam int SW = rpc_pkg::SETTLE_W;

    // Reload value of the settling counter, cut to its width on purpose
    function automatic logic [SW-1:0] settle_load(input int cyc);
        settle_load = SW'(cyc);
    endfunction

    // Forced pin levels land only where the select bit is set
    function automatic logic [NUM_REGS-1:0] merge_sel(
        input logic [NUM_REGS-1:0] cur,
        input logic [NUM_REGS-1:0] forced,
        input logic [NUM_REGS-1:0] sel
    );
        merge_sel = (cur & ~sel) | (forced & sel);
    endfunction

    assign raw_bus = {ctrl_pins.dev_clk, ctrl_pins.out_en_n, ctrl_pins.preload_high_voltage_level, q_pin_in};

    // Pins pass two flip-flops
    rpc_sync #(
        .WIDTH(NUM_REGS + 3)
    ) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .async_in(raw_bus),
        .sync_out(sync_bus)
    );

    assign dclk_s = sync_bus[NUM_REGS+2];
    assign oe_n_s = sync_bus[NUM_REGS+1];
    assign hv_s = sync_bus[NUM_REGS];
    assign qin_s = sync_bus[NUM_REGS-1:0];
    assign dclk_rise = dclk_s & ~dclk_prev_reg;

    // Decoded sequencer events, shared by the sequencer, settling and output groups below
    assign in_normal = (state_reg == rpc_pkg::RPC_NORMAL);
    assign enter_req = in_normal && hv_s && !dclk_s;
    assign capture_req = (state_reg == rpc_pkg::RPC_ARMED) && hv_s && dclk_rise;
    assign exit_req = (state_reg == rpc_pkg::RPC_LOADED) && !hv_s;

    // Clock pin edge detector, next value
    always_comb begin
        dclk_prev_next = dclk_prev_reg;
        // Track the pin only while enabled, so no edge is lost in a freeze
        if (clk_en) begin
            dclk_prev_next = dclk_s;
        end
    end

    // Clock pin edge detector register; reset matches the idle low pin
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dclk_prev_reg <= 1'b0;
        end else begin
            dclk_prev_reg <= dclk_prev_next;
        end
    end

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        if (clk_en) begin
            case (state_reg)
                // Normal operation
                rpc_pkg::RPC_NORMAL: begin
                    if (enter_req) begin
                        state_next = rpc_pkg::RPC_ARMED;
                    end
                end
                // Waiting for capture pulse
                rpc_pkg::RPC_ARMED: begin
                    // Level dropped before any pulse: abandon quietly
                    if (!hv_s) begin
                        state_next = rpc_pkg::RPC_NORMAL;
                    end else if (capture_req) begin
                        state_next = rpc_pkg::RPC_LOADED;
                    end
                end
                // Captured, waiting for exit; further pulses are ignored
                rpc_pkg::RPC_LOADED: begin
                    if (exit_req) begin
                        state_next = rpc_pkg::RPC_NORMAL;
                    end
                end
                // Unused code falls back to normal
                default: begin
                    state_next = rpc_pkg::RPC_NORMAL;
                end
            endcase
        end
    end

    // Sequencer register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= rpc_pkg::RPC_NORMAL;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        settle_next = settle_reg;
        if (clk_en) begin
            // Entry, capture and exit each restart the interval
            if (enter_req || capture_req || exit_req) begin
                settle_next = settle_load(SETTLE_CYC);
            end else if (settle_reg != '0) begin
                // Count down and rest at zero
                settle_next = settle_reg - 1'b1;
            end
        end
    end

    // Settling counter register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            settle_reg <= '0;
        end else begin
            settle_reg <= settle_next;
        end
    end

    // Output registers next value
    always_comb begin
        q_next = q_reg;
        if (clk_en) begin
            if (capture_req) begin
                q_next = merge_sel(q_reg, qin_s, load_sel);
            end else if (in_normal && dclk_rise) begin
                q_next = next_state;
            end
        end
    end

    // Output registers
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q_reg <= rpc_pkg::REG_CLEAR_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_pin_out = q_reg;
    assign q_pin_oe = (in_normal && !oe_n_s) ? {NUM_REGS{1'b1}} : '0;
    // Any state but normal counts as preload
    assign preload_active = !in_normal;
    assign settle_done = (settle_reg == '0);
endmodule

/* File: tb/rpc_preload_assertions.sv */
// Purpose: Port checker for rpc_preload
// Assumes: Pin levels reach the registers within five edges
// Notes: Bound to every rpc_preload
`timescale 1ns/1ps
module rpc_preload_assertions #(
    parameter int NUM_REGS = 8,
    parameter int SETTLE_CYC = 10
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Pins
    input wire rpc_pkg::rpc_ctrl_pins_t ctrl_pins,
    input wire logic [NUM_REGS-1:0] load_sel,
    input wire logic [NUM_REGS-1:0] q_pin_in,
    input wire logic [NUM_REGS-1:0] q_pin_out,
    input wire logic [NUM_REGS-1:0] q_pin_oe,
    input wire logic preload_active,
    input wire logic settle_done
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Normal mode with the enable pin asserted
    sequence s_run;
        !preload_active && !ctrl_pins.out_en_n;
    endsequence
    property p_clear;
        $fell(sys_rst) |-> q_pin_out == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("not cleared");
    property p_cap;
        preload_active && $rose(ctrl_pins.dev_clk) |-> ##[2:5] ((q_pin_out ^ q_pin_in) & load_sel) == '0;
    endproperty
    a_cap: assert property (p_cap) else $error("no capture");
    property p_keep;
        preload_active && $past(preload_active) |-> ((q_pin_out ^ $past(q_pin_out)) & ~load_sel) == '0;
    endproperty
    a_keep: assert property (p_keep) else $error("other reg changed");
    property p_hiz;
        preload_active |-> q_pin_oe == '0;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pin driven");
    property p_show;
        s_run [*3] |-> q_pin_oe == '1;
    endproperty
    a_show: assert property (p_show) else $error("pin not driven");
    // Preload entered: sequencer left normal mode
    sequence s_enter;
        $rose(preload_active);
    endsequence
    // Settling count runs down from its reload value
    sequence s_settle;
        !settle_done ##[1:SETTLE_CYC] settle_done;
    endsequence
    property p_settle;
        s_enter |-> s_settle;
    endproperty
    a_settle: assert property (p_settle) else $error("settle count wrong");
    property p_frz;
        !clk_en |=> $stable(q_pin_out);
    endproperty
    a_frz: assert property (p_frz) else $error("frozen register moved");
endmodule
bind rpc_preload rpc_preload_assertions #(.NUM_REGS(NUM_REGS), .SETTLE_CYC(SETTLE_CYC)) u_chk (.ref_clk, .sys_rst,
    .clk_en, .ctrl_pins, .load_sel, .q_pin_in, .q_pin_out, .q_pin_oe, .preload_active, .settle_done);

/* File: tb/rpc_tester.sv */
// Purpose: Tester that drives the device pins
// Assumes: Steps change at falling edges
// Notes: Undriven pins show the inverse of their last level, except forced pins, which show their forced value
`timescale 1ns/1ps
module rpc_tester (
    // Clock
    input wire logic ref_clk,
    // Pins to device
    output rpc_pkg::rpc_ctrl_pins_t ctrl_pins,
    output logic [7:0] load_sel,
    output logic [7:0] q_pin_in,
    // Device drive
    input wire logic [7:0] q_pin_out,
    input wire logic [7:0] q_pin_oe
);
    logic [7:0] frc = 8'h00;
    logic [7:0] fv = 8'h00;
    logic [7:0] last = 8'h00;
    always_comb q_pin_in = (q_pin_oe & q_pin_out) | (~q_pin_oe & ((frc & fv) | (~frc & ~last)));
    always @(posedge ref_clk) last <= q_pin_in;
    initial begin
        ctrl_pins = '0;
        load_sel = 8'h00;
    end
    task wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task pulse;
        ctrl_pins.dev_clk = 1'b1;
        wt(12);
        ctrl_pins.dev_clk = 1'b0;
        wt(12);
    endtask
    task preload(input int i, input logic v);
        load_sel = 8'h01 << i;
        ctrl_pins.preload_high_voltage_level = 1'b1;
        wt(12);
        frc[i] = 1'b1;
        fv[i] = v;
        wt(12);
        pulse();
        frc[i] = 1'b0;
        wt(12);
        ctrl_pins.preload_high_voltage_level = 1'b0;
        wt(12);
    endtask
    // Output-enable pin at a plain logic level, high disables
    task drive_en(input logic en_n);
        ctrl_pins.out_en_n = en_n;
        wt(12);
    endtask
endmodule

/* File: tb/tb.sv */
// Purpose: Testbench for rpc_preload
// Assumes: Tester model drives the pins
// Notes: Expected images queued, checked on event
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] next_state = 8'h00;
    logic [7:0] exp_q = 8'h00;
    logic [7:0] exp_oe = 8'hff;
    logic clk_en = 1'b1;
    logic [15:0] got;
    logic [7:0] q_pin_in, q_pin_out, q_pin_oe, load_sel;
    rpc_pkg::rpc_ctrl_pins_t ctrl_pins;
    logic [15:0] fifo[$];
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    event look;
    initial forever #5 ref_clk = ~ref_clk;
    rpc_preload u_dut (.ref_clk, .sys_rst, .clk_en, .ctrl_pins, .load_sel, .next_state, .q_pin_in,
        .q_pin_out, .q_pin_oe, .preload_active(), .settle_done());
    rpc_tester u_tst (.ref_clk, .ctrl_pins, .load_sel, .q_pin_in, .q_pin_out, .q_pin_oe);
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t q=%h exp=%h", $time, seen, exp);
        end
    endtask
    task note;
        fifo.push_back({exp_oe, exp_q});
        -> look;
    endtask
    always @(look) begin
        got = fifo.pop_front();
        check(q_pin_out, got[7:0]);
        check(q_pin_oe, got[15:8]);
    end
    task conclude;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'ha4d4a4dd));
        repeat (6) @(negedge ref_clk);
        sys_rst = 1'b0;
        u_tst.wt(12);
        note();
        $display("reset done");
        for (int i = 0; i < 16; i++) begin
            if (i == 8) begin
                // Frozen enable: a pulse must not move the registers
                clk_en = 1'b0;
                next_state = 8'($urandom);
                u_tst.pulse();
                clk_en = 1'b1;
                u_tst.wt(2);
                note();
                next_state = 8'($urandom);
                exp_q = next_state;
                u_tst.pulse();
                note();
            end
            exp_q[i%8] = 1'($urandom);
            u_tst.preload(i % 8, exp_q[i%8]);
            note();
        end
        $display("preload done");
        // Enable pin high: no register may drive its pin
        exp_oe = 8'h00;
        u_tst.drive_en(1'b1);
        note();
        exp_oe = 8'hff;
        u_tst.drive_en(1'b0);
        note();
        $display("enable done");
        sys_rst = 1'b1;
        u_tst.wt(2);
        sys_rst = 1'b0;
        exp_q = 8'h00;
        u_tst.wt(12);
        note();
        $display("second reset done");
        conclude();
    end
endmodule
